// *** logic/vmi_pkg.sv ***
// Purpose: shared constants and types of the monitor-2 arming controller
// Assumes: mclk at 20 MHz, registers reached over AXI4-Lite
// Notes:   offsets are byte addresses of 32-bit words
package vmi_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int MCLK_NS = 50;
	localparam int MCLK_HZ = 20_000_000;
	localparam int TMR_W   = 20;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_CFG   = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_ISTAT = 8'h0c;
	localparam logic [7:0] OFS_IMASK = 8'h10;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_ARM    = 0;
	localparam int CTRL_DISARM = 1;
	localparam int CTRL_NOFILT = 2;
	localparam int CTRL_USEF   = 3;
	localparam int EV_ARMED    = 0;
	localparam int EV_DISARMED = 1;
	localparam int EV_DETECT   = 2;
	localparam int EV_REFUSED  = 3;
	localparam int EV_W        = 4;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0]  RST_CTRL = 4'h0;
	localparam logic [8:0]  RST_CFG  = 9'h000;
	localparam logic [EV_W-1:0] RST_EV = 4'h0;
	localparam logic [1:0]  RESP_OK  = 2'b00;
	localparam logic [1:0]  RESP_ERR = 2'b10;
	// ------------------------------------------------------------
	// device-facing bundles
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] threshold;
		logic       circuit_en;
		logic [1:0] filter_clk_sel;
		logic       filter_off;
		logic       irq_or_reset_sel;
		logic [1:0] irq_timing_sel;
		logic       irq_type_sel;
		logic       flag_clr;
		logic       irq_reset_en;
		logic       cmp_out_en;
	} vmi_mon2_type;
	typedef struct packed {
		logic circuit_en;
		logic irq_reset_en;
		logic cmp_out_en;
	} vmi_mon1_type;
	// filter off, interrupt mode, everything else cleared
	localparam vmi_mon2_type RST_MON2 = '{4'h0, 1'b0, 2'b00, 1'b1,
		1'b0, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0};
endpackage

// *** logic/vmi_sync.sv ***
// Purpose: two-flop synchroniser for device pins
// Assumes: inputs are levels that stay put for several mclk cycles
// Notes:   first stage is read by the second stage only
`timescale 1ns/10ps
module vmi_sync #(
	parameter int W = 2
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         nrst,
	// levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;

	// ------------------------------------------------------------
	// two stages
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule

// *** logic/vmi_timer.sv ***
// Purpose: down counter for the settle and filter waits
// Assumes: load is a one-cycle pulse, value at least one
// Notes:   done pulses once, at least val edges after load
`timescale 1ns/10ps
module vmi_timer
	import vmi_pkg::*;
(
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             nrst,
	// control
	input  wire logic             load,
	input  wire logic [TMR_W-1:0] val,
	output logic                  done
);
	logic [TMR_W-1:0] cnt_q;

	// ------------------------------------------------------------
	// count down, pulse when the last cycle passes
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
			done  <= 1'b0;
		end else begin
			done <= (cnt_q == TMR_W'(1)) && !load;
			if (load) begin
				cnt_q <= val;
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - TMR_W'(1);
			end
		end
	end
endmodule

// *** logic/vmi_ctrl.sv ***
// Purpose: arms and disarms supply monitor 2 as an interrupt source
// Assumes: device pins are static levels sampled by the device
// Notes:   software orders via AXI4-Lite; one step per mclk cycle
// What this block does
// - write the threshold first; filterless variant uses two bits
// - filtered variant: circuit enable set second, before filter setup
// - wait the monitor settle time after circuit enable
// - filter in use: pick sampling clock after the settle wait
// - filter on by clearing filter-off after clock choice
// - after filter on, wait at least 2n+3 low-speed osc cycles
// - clear irq-or-reset select so detection raises an interrupt
// - choose interrupt timing field and interrupt type bit
// - clear the detection flag before enabling interrupts
// - after flag clear, set the irq/reset enable
// - filtered variant: comparison output enable comes last
// - filterless order: mode, circuit, wait, cmp out, clear, enable
// - filterless: monitor-1 enables off before other changes
// - disarm of filtered variant sets filter-off when filter used
`timescale 1ns/10ps
module vmi_ctrl
	import vmi_pkg::*;
#(
	parameter int SETTLE_NS = 300_000,
	parameter int LOW_SPEED_OSC_HZ   = 250_000
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// axi4-lite write
	input  wire logic [7:0]        s_awaddr,
	input  wire logic              s_awvalid,
	output logic                   s_awready,
	input  wire logic [31:0]       s_wdata,
	input  wire logic [3:0]        s_wstrb,
	input  wire logic              s_wvalid,
	output logic                   s_wready,
	output logic [1:0]             s_bresp,
	output logic                   s_bvalid,
	input  wire logic              s_bready,
	// axi4-lite read
	input  wire logic [7:0]        s_araddr,
	input  wire logic              s_arvalid,
	output logic                   s_arready,
	output logic [31:0]            s_rdata,
	output logic [1:0]             s_rresp,
	output logic                   s_rvalid,
	input  wire logic              s_rready,
	// device pins
	output vmi_pkg::vmi_mon2_type  mon2_q,
	output vmi_pkg::vmi_mon1_type  mon1_q,
	input  wire logic              mon2_detect_flag,
	input  wire logic              mon2_irq_req,
	// interrupt
	output logic                   irq_q
);
	import vmi_pkg::*;

	localparam int SETTLE_CYC = (SETTLE_NS + MCLK_NS - 1) / MCLK_NS;

	typedef enum logic [4:0] {
		ST_IDLE, ST_M1OFF, ST_LEVEL, ST_CIRC, ST_SETTLE, ST_FSAMP,
		ST_FON, ST_FWAIT, ST_MODE, ST_TIMING, ST_CLR, ST_IEN, ST_CMP,
		ST_DONE, ST_D_CMP, ST_D_IEN, ST_D_FOFF, ST_D_CIRC
	} vmi_state_type;

	vmi_state_type    st_q;
	vmi_state_type    st_d;
	logic [3:0]       ctrl_q;
	logic [8:0]       cfg_q;
	logic [EV_W-1:0]  ev_q;
	logic [EV_W-1:0]  mask_q;
	logic [EV_W-1:0]  ev_set;
	logic             nofilt_q;
	logic             usef_q;
	logic             armed_q;
	logic             aw_have_q;
	logic             w_have_q;
	logic [7:0]       aw_addr_q;
	logic [31:0]      w_data_q;
	logic [3:0]       w_strb_q;
	logic             wr_go;
	logic             tmr_load;
	logic [TMR_W-1:0] tmr_val;
	logic             tmr_done;
	logic [1:0]       pins_s;
	logic             req_prev_q;

	// filter wait in mclk cycles: 2n+3 osc cycles, n = 2 << sel
	function automatic logic [TMR_W-1:0] fwait(input logic [1:0] s);
		int n;
		n = 2 << s;
		return TMR_W'(((2 * n + 3) * MCLK_HZ + LOW_SPEED_OSC_HZ - 1) / LOW_SPEED_OSC_HZ);
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers and wait timer
	// ------------------------------------------------------------
	vmi_sync #(.W(2)) u_sync (
		.mclk (mclk),
		.nrst (nrst),
		.din  ({mon2_irq_req, mon2_detect_flag}),
		.dout (pins_s)
	);

	vmi_timer u_tmr (
		.mclk (mclk),
		.nrst (nrst),
		.load (tmr_load),
		.val  (tmr_val),
		.done (tmr_done)
	);

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	assign wr_go = aw_have_q && w_have_q && !s_bvalid;

	// address and data taken in either order, response after both
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			s_bvalid  <= 1'b0;
			s_bresp   <= RESP_OK;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_have_q <= 1'b1;
				s_awready <= 1'b0;
				aw_addr_q <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_have_q <= 1'b1;
				s_wready <= 1'b0;
				w_data_q <= s_wdata;
				w_strb_q <= s_wstrb;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				s_bvalid  <= 1'b1;
				s_bresp   <= (aw_addr_q <= OFS_IMASK &&
					aw_addr_q[1:0] == 2'b00) ? RESP_OK : RESP_ERR;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid  <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// software registers; control bits are low byte only
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= RST_CTRL;
			cfg_q  <= RST_CFG;
			mask_q <= RST_EV;
		end else begin
			ctrl_q[CTRL_ARM]    <= 1'b0;
			ctrl_q[CTRL_DISARM] <= 1'b0;
			if (wr_go && w_strb_q[0]) begin
				unique case (aw_addr_q)
					OFS_CTRL:  ctrl_q <= w_data_q[3:0];
					OFS_IMASK: mask_q <= w_data_q[EV_W-1:0];
					default: ;
				endcase
				// config is frozen during a sequence so steps agree
				if (aw_addr_q == OFS_CFG && st_q == ST_IDLE) begin
					cfg_q[7:0] <= w_data_q[7:0];
				end
			end
			if (wr_go && w_strb_q[1] && aw_addr_q == OFS_CFG &&
				st_q == ST_IDLE) begin
				cfg_q[8] <= w_data_q[8];
			end
		end
	end

	// ------------------------------------------------------------
	// read channel, one cycle after the address is taken
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= '0;
			s_rresp   <= RESP_OK;
		end else begin
			if (s_arvalid && s_arready) begin
				s_arready <= 1'b0;
				s_rvalid  <= 1'b1;
				s_rresp   <= RESP_OK;
				unique case (s_araddr)
					OFS_CTRL:  s_rdata <= {28'h0, ctrl_q};
					OFS_CFG:   s_rdata <= {23'h0, cfg_q};
					OFS_STAT:  s_rdata <= {23'h0, 5'(st_q),
						pins_s, armed_q, st_q != ST_IDLE};
					OFS_ISTAT: s_rdata <= {28'h0, ev_q};
					OFS_IMASK: s_rdata <= {28'h0, mask_q};
					default: begin
						s_rdata <= '0;
						s_rresp <= RESP_ERR;
					end
				endcase
			end
			if (s_rvalid && s_rready) begin
				s_rvalid  <= 1'b0;
				s_arready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// sequencer next state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: begin
				if (ctrl_q[CTRL_ARM] && !armed_q) begin
					st_d = ctrl_q[CTRL_NOFILT] ? ST_M1OFF : ST_LEVEL;
				end else if (ctrl_q[CTRL_DISARM] && armed_q) begin
					st_d = ST_D_CMP;
				end
			end
			ST_M1OFF:  st_d = ST_LEVEL;
			ST_LEVEL:  st_d = nofilt_q ? ST_MODE : ST_CIRC;
			ST_CIRC:   st_d = ST_SETTLE;
			ST_SETTLE: begin
				if (tmr_done) begin
					st_d = nofilt_q ? ST_CMP :
						(usef_q ? ST_FSAMP : ST_MODE);
				end
			end
			ST_FSAMP:  st_d = ST_FON;
			ST_FON:    st_d = ST_FWAIT;
			ST_FWAIT:  st_d = tmr_done ? ST_MODE : ST_FWAIT;
			ST_MODE:   st_d = ST_TIMING;
			ST_TIMING: st_d = nofilt_q ? ST_CIRC : ST_CLR;
			ST_CLR:    st_d = ST_IEN;
			ST_IEN:    st_d = nofilt_q ? ST_DONE : ST_CMP;
			ST_CMP:    st_d = nofilt_q ? ST_CLR : ST_DONE;
			ST_DONE:   st_d = ST_IDLE;
			ST_D_CMP:  st_d = ST_D_IEN;
			ST_D_IEN:  st_d = (usef_q && !nofilt_q) ? ST_D_FOFF :
				ST_D_CIRC;
			ST_D_FOFF: st_d = ST_D_CIRC;
			ST_D_CIRC: st_d = ST_IDLE;
			default:   st_d = ST_IDLE;
		endcase
	end

	// waits are loaded as their state is entered
	assign tmr_load = (st_q == ST_CIRC) || (st_q == ST_FON);
	assign tmr_val  = (st_q == ST_CIRC) ? TMR_W'(SETTLE_CYC) :
		fwait(mon2_q.filter_clk_sel);

	// ------------------------------------------------------------
	// state, variant latch and armed flag
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_q     <= ST_IDLE;
			nofilt_q <= 1'b0;
			usef_q   <= 1'b0;
			armed_q  <= 1'b0;
		end else begin
			st_q <= st_d;
			if (st_q == ST_IDLE && ctrl_q[CTRL_ARM] && !armed_q) begin
				nofilt_q <= ctrl_q[CTRL_NOFILT];
				usef_q   <= ctrl_q[CTRL_USEF] && !ctrl_q[CTRL_NOFILT];
			end
			if (st_q == ST_DONE) begin
				armed_q <= 1'b1;
			end else if (st_q == ST_D_CIRC) begin
				armed_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// device pin drive, one documented step per state
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mon2_q <= RST_MON2;
			mon1_q <= '0;
		end else begin
			mon2_q.flag_clr <= 1'b0;
			unique case (st_d)
				ST_M1OFF: mon1_q <= '0;
				ST_LEVEL: begin
					// narrow variant has no upper level bits; only it comes
					// via M1OFF, nofilt_q is not yet latched when idle leaves
					mon2_q.threshold <= (st_q == ST_M1OFF) ?
						{2'b00, cfg_q[1:0]} : cfg_q[3:0];
				end
				ST_CIRC:  mon2_q.circuit_en <= 1'b1;
				ST_FSAMP: mon2_q.filter_clk_sel <= cfg_q[5:4];
				ST_FON:   mon2_q.filter_off <= 1'b0;
				ST_MODE:  mon2_q.irq_or_reset_sel <= 1'b0;
				ST_TIMING: begin
					mon2_q.irq_timing_sel <= cfg_q[7:6];
					mon2_q.irq_type_sel   <= cfg_q[8];
				end
				ST_CLR:    mon2_q.flag_clr <= 1'b1;
				ST_IEN:    mon2_q.irq_reset_en <= 1'b1;
				ST_CMP:    mon2_q.cmp_out_en <= 1'b1;
				ST_D_CMP:  mon2_q.cmp_out_en <= 1'b0;
				ST_D_IEN:  mon2_q.irq_reset_en <= 1'b0;
				ST_D_FOFF: mon2_q.filter_off <= 1'b1;
				ST_D_CIRC: mon2_q.circuit_en <= 1'b0;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// sticky events, write one to clear; a new event wins
	// ------------------------------------------------------------
	always_comb begin
		ev_set = '0;
		ev_set[EV_ARMED]    = st_q == ST_DONE;
		ev_set[EV_DISARMED] = st_q == ST_D_CIRC;
		// request only exists when enabled in interrupt mode
		ev_set[EV_DETECT]   = pins_s[1] && !req_prev_q;
		ev_set[EV_REFUSED]  = (ctrl_q[CTRL_ARM] && (armed_q ||
			st_q != ST_IDLE)) || (ctrl_q[CTRL_DISARM] && !armed_q);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ev_q       <= RST_EV;
			req_prev_q <= 1'b0;
			irq_q      <= 1'b0;
		end else begin
			req_prev_q <= pins_s[1];
			if (wr_go && w_strb_q[0] && aw_addr_q == OFS_ISTAT) begin
				ev_q <= (ev_q & ~w_data_q[EV_W-1:0]) | ev_set;
			end else begin
				ev_q <= ev_q | ev_set;
			end
			irq_q <= |(ev_q & mask_q);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [TMR_W-1:0] since_en_q;
	logic [TMR_W-1:0] since_fon_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			since_en_q  <= '0;
			since_fon_q <= '0;
		end else begin
			since_en_q  <= !mon2_q.circuit_en ? '0 :
				since_en_q + TMR_W'(!(&since_en_q));
			since_fon_q <= mon2_q.filter_off ? '0 :
				since_fon_q + TMR_W'(!(&since_fon_q));
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	AST_LEVEL_NARROW: assert property (
		nofilt_q && $changed(mon2_q.threshold) |->
		mon2_q.threshold[3:2] == 2'b00)
		else $error("narrow variant got upper level bits");
	AST_CIRC_SECOND: assert property (
		$rose(mon2_q.circuit_en) && !nofilt_q |->
		mon2_q.filter_off && !mon2_q.irq_reset_en)
		else $error("circuit enable not before filter setup");
	AST_SETTLE: assert property (
		$changed(mon2_q.filter_clk_sel) || $rose(mon2_q.cmp_out_en) ||
		$rose(mon2_q.irq_reset_en) |->
		since_en_q >= TMR_W'(SETTLE_CYC))
		else $error("settle wait cut short");
	AST_FSAMP_FIRST: assert property (
		$fell(mon2_q.filter_off) |->
		$past(mon2_q.filter_clk_sel) == cfg_q[5:4])
		else $error("filter on before clock choice");
	AST_FILT_ON: assert property (
		$fell(mon2_q.filter_off) |-> usef_q && mon2_q.circuit_en)
		else $error("filter enabled unexpectedly");
	AST_FWAIT: assert property (
		$rose(mon2_q.flag_clr) && usef_q |->
		since_fon_q >= fwait(mon2_q.filter_clk_sel))
		else $error("filter wait cut short");
	AST_IRQ_MODE: assert property (
		$rose(mon2_q.irq_reset_en) |-> !mon2_q.irq_or_reset_sel)
		else $error("enable while in reset mode");
	AST_TIMING: assert property (
		$rose(mon2_q.irq_reset_en) |->
		mon2_q.irq_timing_sel == cfg_q[7:6] &&
		mon2_q.irq_type_sel == cfg_q[8])
		else $error("interrupt timing or type not applied");
	AST_CLR_THEN_EN: assert property (
		mon2_q.flag_clr && st_q == ST_CLR |=> $rose(mon2_q.irq_reset_en))
		else $error("enable does not follow flag clear");
	AST_EN_AFTER_CLR: assert property (
		$rose(mon2_q.irq_reset_en) |-> $past(mon2_q.flag_clr))
		else $error("enable without prior flag clear");
	AST_CMP_LAST: assert property (
		$rose(mon2_q.cmp_out_en) && !nofilt_q |-> mon2_q.irq_reset_en)
		else $error("compare output before interrupt enable");
	AST_NOFILT_ORDER: assert property (
		$rose(mon2_q.cmp_out_en) && nofilt_q |->
		!mon2_q.irq_reset_en ##1 !mon2_q.irq_reset_en ##2
		mon2_q.irq_reset_en)
		else $error("filterless order broken");
	AST_M1_OFF: assert property (
		nofilt_q && $changed(mon2_q.threshold) |-> mon1_q == '0)
		else $error("monitor 1 still enabled");
	AST_DISARM_FOFF: assert property (
		$rose(mon2_q.filter_off) |->
		!mon2_q.irq_reset_en && !mon2_q.cmp_out_en && mon2_q.circuit_en)
		else $error("filter off out of order");
	AST_IRQ_OUT: assert property (
		ev_q[EV_ARMED] && mask_q[EV_ARMED] |=> irq_q)
		else $error("interrupt output missed");

	COV_ARM_FILT:  cover property ($rose(armed_q) && usef_q);
	COV_ARM_NOF:   cover property ($rose(armed_q) && nofilt_q);
	COV_DISARM:    cover property (st_q == ST_D_FOFF);
	COV_DETECT:    cover property (ev_set[EV_DETECT] && irq_q);
endmodule

// *** tb/vmi_dev_model.sv ***
// Purpose: behavioural supply monitor 2 facing the arming controller
// Assumes: trip is the comparator result, driven by the bench
// Notes:   low-speed osc ticks are taken as mclk ticks to keep runs short
`timescale 1ns/10ps
module vmi_dev_model (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  nrst,
	// controller pins and comparator
	input  wire vmi_pkg::vmi_mon2_type mon2_q,
	input  wire logic                  trip,
	// device outputs
	output logic                       mon2_detect_flag,
	output logic                       mon2_irq_req
);
	import vmi_pkg::*;
	logic [4:0] div_q;
	logic       filt_q;
	logic       lvl;
	logic       live;
	// ------------------------------------------------------------
	// digital filter
	// ------------------------------------------------------------
	// sample the comparator once every n ticks, n = 2 << sel
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			div_q  <= 5'h00;
			filt_q <= 1'b0;
		end else if (div_q >= (5'h02 << mon2_q.filter_clk_sel) - 5'h01) begin
			div_q  <= 5'h00;
			filt_q <= trip;
		end else begin
			div_q <= div_q + 5'h01;
		end
	end
	assign lvl  = mon2_q.filter_off ? trip : filt_q;
	// interrupt mode only: enable set and select cleared
	assign live = mon2_q.irq_reset_en && !mon2_q.irq_or_reset_sel;
	// ------------------------------------------------------------
	// detection flag
	// ------------------------------------------------------------
	// clear pulse wins so a stale trip cannot survive arming
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mon2_detect_flag <= 1'b0;
		end else if (mon2_q.flag_clr) begin
			mon2_detect_flag <= 1'b0;
		end else if (lvl && mon2_q.circuit_en && live) begin
			mon2_detect_flag <= 1'b1;
		end
	end
	assign mon2_irq_req = mon2_detect_flag && live;
endmodule

// *** tb/tb_vmi_ctrl.sv ***
// Purpose: self-checking bench of the monitor-2 arming controller
// Assumes: short settle and fast osc parameters for simulation
// Notes:   pin step times are logged by a monitor and compared
`timescale 1ns/10ps
module tb_vmi_ctrl;
	import vmi_pkg::*;
	localparam int SETTLE = 20; // 1000 ns of 50 ns cycles
	localparam int FWAIT  = 44; // (2*4+3) osc cycles of 4 mclk each
	logic         mclk, nrst, trip, irq_q, flag, req;
	logic [7:0]   awaddr, araddr;
	logic         awvalid, wvalid, bready, arvalid, rready;
	logic         awready, wready, bvalid, arready, rvalid;
	logic [31:0]  wdata, rdata, rd;
	logic [1:0]   bresp, rresp, rs;
	vmi_mon2_type mon2_q, pm;
	vmi_mon1_type mon1_q;
	int           error_cnt = 0;
	int           n_tests = 0;
	int           cyc = 0;
	int           tc, tf, tk, ti, tp;
	vmi_ctrl #(.SETTLE_NS(1000), .LOW_SPEED_OSC_HZ(5_000_000)) vmi_ctrl_i (
		.mclk(mclk), .nrst(nrst), .s_awaddr(awaddr), .s_awvalid(awvalid),
		.s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf),
		.s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
		.s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
		.s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
		.s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
		.mon2_q(mon2_q), .mon1_q(mon1_q), .mon2_detect_flag(flag),
		.mon2_irq_req(req), .irq_q(irq_q));
	vmi_dev_model vmi_dev_model_i (.mclk(mclk), .nrst(nrst),
		.mon2_q(mon2_q), .trip(trip), .mon2_detect_flag(flag),
		.mon2_irq_req(req));
	// clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// log the cycle of the circuit, filter-on, clear, enable and compare pin steps
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		pm <= mon2_q;
		if (mon2_q.circuit_en && !pm.circuit_en) tc <= cyc;
		if (!mon2_q.filter_off && pm.filter_off) tf <= cyc;
		if (mon2_q.flag_clr) tk <= cyc;
		if (mon2_q.irq_reset_en && !pm.irq_reset_en) ti <= cyc;
		if (mon2_q.cmp_out_en && !pm.cmp_out_en) tp <= cyc;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// write, holding each channel until its own ready
	task automatic wrc(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bit done;
		done = 0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				chk(32'(bresp), 32'(er));
				bready <= 1'b0;
				done = 1;
			end
		end
	endtask
	task automatic rdx(input logic [7:0] a);
		bit done;
		done = 0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rd = rdata;
				rs = rresp;
				rready <= 1'b0;
				done = 1;
			end
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		rdx(a);
		chk(rd, e);
		chk(32'(rs), 32'(er));
	endtask
	// bounded wait for the interrupt line
	task automatic wait_irq();
		for (int i = 0; i < 3000 && irq_q !== 1'b1; i++) @(posedge mclk);
		chk(32'(irq_q), 32'h1);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		trip = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		chk(32'(mon2_q), 32'(RST_MON2));
		chk(32'(mon1_q), 32'h0);
		rdc(OFS_CFG, 32'h0, RESP_OK);
		rdc(OFS_ISTAT, 32'h0, RESP_OK);
		wrc(8'h40, 32'h1, RESP_ERR);
		wrc(8'h05, 32'h1, RESP_ERR);
		rdc(8'h40, 32'h0, RESP_ERR);
		// filtered arm, level a, sel 1, timing 2, type 1
		wrc(OFS_CFG, 32'h19a, RESP_OK);
		wrc(OFS_IMASK, 32'hf, RESP_OK);
		wrc(OFS_CTRL, 32'h9, RESP_OK);
		wait_irq();
		chk(32'(mon2_q.threshold), 32'ha);
		chk(32'(tc < tf), 32'h1);
		chk(32'(tf - tc >= SETTLE), 32'h1);
		chk(32'(mon2_q.filter_clk_sel), 32'h1);
		chk(32'(mon2_q.filter_off), 32'h0);
		chk(32'(ti - tf >= FWAIT), 32'h1);
		chk(32'(mon2_q.irq_or_reset_sel), 32'h0);
		chk(32'({mon2_q.irq_timing_sel, mon2_q.irq_type_sel}), 32'h5);
		chk(32'(tk > tf && tk < ti), 32'h1);
		chk(32'(mon2_q.irq_reset_en), 32'h1);
		chk(32'(tp > ti && mon2_q.cmp_out_en), 32'h1);
		rdc(OFS_ISTAT, 32'h1, RESP_OK);
		wrc(OFS_ISTAT, 32'h1, RESP_OK);
		repeat (3) @(posedge mclk);
		chk(32'(irq_q), 32'h0);
		// detection reaches status and interrupt
		trip <= 1'b1;
		wait_irq();
		rdx(OFS_STAT);
		chk(32'(rd[3:1]), 32'h7);
		rdc(OFS_ISTAT, 32'h4, RESP_OK);
		trip <= 1'b0;
		wrc(OFS_ISTAT, 32'hf, RESP_OK);
		// arm while armed is refused
		wrc(OFS_CTRL, 32'h9, RESP_OK);
		wait_irq();
		rdc(OFS_ISTAT, 32'h8, RESP_OK);
		wrc(OFS_ISTAT, 32'hf, RESP_OK);
		// disarm leaves everything off, filter off again
		wrc(OFS_CTRL, 32'h2, RESP_OK);
		wait_irq();
		chk(32'(mon2_q.filter_off), 32'h1);
		chk(32'({mon2_q.circuit_en, mon2_q.irq_reset_en,
			mon2_q.cmp_out_en}), 32'h0);
		rdc(OFS_ISTAT, 32'h2, RESP_OK);
		wrc(OFS_ISTAT, 32'hf, RESP_OK);
		trip <= 1'b1;
		repeat (20) @(posedge mclk);
		rdx(OFS_STAT);
		chk(32'(rd[3]), 32'h0);
		trip <= 1'b0;
		// filterless arm, level 7, timing 1, type 0
		wrc(OFS_CFG, 32'h047, RESP_OK);
		wrc(OFS_CTRL, 32'h5, RESP_OK);
		wait_irq();
		chk(32'(mon2_q.threshold[1:0]), 32'h3);
		chk(32'(mon2_q.irq_timing_sel), 32'h1);
		chk(32'(mon1_q), 32'h0);
		chk(32'(mon2_q.filter_off), 32'h1);
		chk(32'(tp - tc >= SETTLE), 32'h1);
		chk(32'(tk > tp && ti > tk), 32'h1);
		rdc(OFS_ISTAT, 32'h1, RESP_OK);
		wrc(OFS_ISTAT, 32'hf, RESP_OK);
		// disarm, then filtered arm with the filter left unused
		wrc(OFS_CTRL, 32'h2, RESP_OK);
		wait_irq();
		rdc(OFS_ISTAT, 32'h2, RESP_OK);
		wrc(OFS_ISTAT, 32'hf, RESP_OK);
		wrc(OFS_CFG, 32'h0ac, RESP_OK);
		wrc(OFS_CTRL, 32'h1, RESP_OK);
		wait_irq();
		chk(32'(mon2_q.threshold), 32'hc);
		chk(32'(mon2_q.filter_off), 32'h1);
		chk(32'(ti - tc >= SETTLE), 32'h1);
		chk(32'(tp > ti && ti > tk), 32'h1);
		rdc(OFS_ISTAT, 32'h1, RESP_OK);
		end_of_test();
	end
	// hold off a hang: fail the run after 1 ms of simulated time
	initial begin
		#1_000_000;
		error_cnt++;
		end_of_test();
	end
endmodule
